//--- verilog/sspu_top.v
// Chosen here: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`include "sspu_regs.vh"
module sspu_top (
	input wire i_core_clk,
	input wire i_rst_n,
	input wire i_hsel,
	input wire [7:0] i_haddr,
	input wire [1:0] i_htrans,
	input wire i_hwrite,
	input wire [2:0] i_hsize,
	input wire [31:0] i_hwdata,
	input wire i_hready,
	output reg o_hreadyout,
	output reg [31:0] o_hrdata,
	output reg o_hresp,
	output reg o_irq,
	input wire i_transfer_clock_pin,
	output reg o_transfer_clock_pin,
	output reg o_transfer_clock_pin_oe,
	input wire i_serial_data_in_pin,
	output reg o_serial_data_out_pin,
	input wire i_clear_to_send_in_n,
	output reg o_request_to_send_out_n,
	output reg o_request_to_send_out_oe,
	input wire i_nmi_n,
	output wire o_aux_serial_out_pin,
	output wire o_aux_serial_out_pin_oe
);
	localparam ST_IDLE = 2'b01;
	localparam ST_SHIFT = 2'b10;

	wire clk_s;
	wire rxd_s;
	wire cts_n_s;
	wire nmi_n_s;

	reg [4:0] channel_control_0;
	reg [4:0] channel_control_1;
	reg [3:0] aux_serial_control;
	reg [3:0] special_mode_control_4;
	reg [7:0] transmit_buffer;
	reg transmit_buffer_empty;
	reg [7:0] receive_buffer;
	reg receive_buffer_full;
	reg overrun_flag;
	reg [2:0] irq_stat;
	reg [2:0] irq_mask;

	reg ap_valid;
	reg ap_write;
	reg [7:0] ap_addr;

	reg [1:0] state;
	reg [7:0] tx_sh;
	reg [7:0] rx_sh;
	reg [3:0] bit_cnt;
	reg rx_active;
	reg int_clk;
	reg [7:0] div_cnt;
	reg clk_prev;
	reg sim_done;
	reg shift_seen;

	wire pol;
	wire ext_clk;
	wire idle_lvl;
	wire clk_now;
	wire lead_edge;
	wire trail_edge;
	wire clk_idle;
	wire cts_ok;
	wire tx_start;
	wire cutoff;
	wire wr_cyc;
	wire rd_rx;
	wire word_done;
	wire [2:0] set_ev;
	wire [2:0] clr_ev;
	wire [4:0] flags;
	wire [7:0] rx_word;
	reg [31:0] next_rdata;
	reg start_ok;
	reg rx_ready;
	reg [2:0] next_irq_stat;

	sspu_sync #(
		.W(4)
	) u_sync (
		.i_core_clk(i_core_clk),
		.i_rst_n(i_rst_n),
		.i_async({i_nmi_n, i_clear_to_send_in_n, i_serial_data_in_pin, i_transfer_clock_pin}),
		.o_sync({nmi_n_s, cts_n_s, rxd_s, clk_s})
	);

	sspu_aux u_aux (
		.i_core_clk(i_core_clk),
		.i_rst_n(i_rst_n),
		.i_ctrl(aux_serial_control),
		.o_sout(o_aux_serial_out_pin),
		.o_sout_oe(o_aux_serial_out_pin_oe)
	);

	assign pol = channel_control_0[`SSPU_C0_POL];
	assign ext_clk = channel_control_0[`SSPU_C0_EXTCLK];
	// Idle level is high for polarity 0 and low for polarity 1
	assign idle_lvl = ~pol;
	assign clk_now = ext_clk ? clk_s : int_clk;
	// Leading edge leaves the idle level and drives data; trailing edge returns and samples
	assign lead_edge = (clk_prev == idle_lvl) && (clk_now != idle_lvl);
	assign trail_edge = (clk_prev != idle_lvl) && (clk_now == idle_lvl);
	assign clk_idle = ~ext_clk | (clk_s == idle_lvl);
	assign cts_ok = ~channel_control_0[`SSPU_C0_CTS_SEL] | ~cts_n_s;
	assign tx_start = (state == ST_IDLE) && start_ok;
	assign cutoff = channel_control_0[`SSPU_C0_CUTOFF] & ~nmi_n_s;
	assign wr_cyc = ap_valid & ap_write;
	assign rd_rx = ap_valid & ~ap_write & (ap_addr == `SSPU_ADDR_RXBUF);
	assign word_done = (state == ST_SHIFT) && trail_edge && (bit_cnt == 4'h7);
	assign rx_word = {rxd_s, rx_sh[7:1]};
	// Live status for polling; send-request reads as active while the pin is pulled low
	assign flags = {~o_request_to_send_out_n, state == ST_SHIFT, overrun_flag, receive_buffer_full,
		transmit_buffer_empty};

	// Event inputs of the sticky status bits
	assign set_ev[`SSPU_IRQ_RX] = word_done & rx_active & ~receive_buffer_full;
	assign set_ev[`SSPU_IRQ_OVR] = word_done & rx_active & receive_buffer_full;
	assign set_ev[`SSPU_IRQ_TX] = (channel_control_1[`SSPU_C1_IRS] ? word_done : tx_start)
		| (channel_control_1[`SSPU_C1_SIM] & channel_control_1[`SSPU_C1_IRS]
		& channel_control_1[`SSPU_C1_ERE] & ~sim_done);
	assign clr_ev = (wr_cyc && ap_addr == `SSPU_ADDR_IRQ_STAT) ? i_hwdata[2:0] : 3'h0;

	// Every start condition alone holds the word back; reception shares them with transmission
	always @* begin
		start_ok = channel_control_1[`SSPU_C1_TE];
		if (transmit_buffer_empty) begin
			start_ok = 1'b0;
		end
		if (!cts_ok) begin
			start_ok = 1'b0;
		end
		if (!clk_idle) begin
			start_ok = 1'b0;
		end
	end

	// Receiver readiness for the send-request pin: from a buffered word until the peer clocks
	always @* begin
		rx_ready = 1'b0;
		if (ext_clk && channel_control_1[`SSPU_C1_RE] && channel_control_1[`SSPU_C1_TE]
			&& !receive_buffer_full) begin
			case (state)
			ST_IDLE: begin
				rx_ready = !transmit_buffer_empty;
			end
			ST_SHIFT: begin
				// A launched word still waits for the peer; its first leading edge starts reception
				rx_ready = !shift_seen && !lead_edge;
			end
			default: begin
				rx_ready = 1'b0;
			end
			endcase
		end
	end

	// Set wins over a write-one clear in the same cycle
	always @* begin
		next_irq_stat = (irq_stat & ~clr_ev) | set_ev;
	end

	// AHB-Lite slave: one wait state on every transfer so read data leave a flip-flop
	always @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			ap_valid <= 1'b0;
			ap_write <= 1'b0;
			ap_addr <= 8'h00;
			o_hreadyout <= 1'b1;
			o_hrdata <= 32'h0000_0000;
			o_hresp <= 1'b0;
		end else begin
			o_hresp <= 1'b0;
			if (ap_valid) begin
				ap_valid <= 1'b0;
				o_hreadyout <= 1'b1;
				o_hrdata <= ap_write ? 32'h0000_0000 : next_rdata;
			end else if (i_hsel && i_htrans[1] && i_hready) begin
				ap_valid <= 1'b1;
				ap_write <= i_hwrite;
				ap_addr <= {i_haddr[7:2], 2'b00};
				o_hreadyout <= 1'b0;
			end
		end
	end

	always @* begin
		next_rdata = 32'h0000_0000;
		case (ap_addr)
		`SSPU_ADDR_CTRL0: next_rdata[4:0] = channel_control_0;
		`SSPU_ADDR_CTRL1: next_rdata[4:0] = channel_control_1;
		`SSPU_ADDR_TXBUF: next_rdata[7:0] = transmit_buffer;
		`SSPU_ADDR_RXBUF: next_rdata[8:0] = {overrun_flag, receive_buffer};
		`SSPU_ADDR_IRQ_STAT: next_rdata[2:0] = irq_stat;
		`SSPU_ADDR_IRQ_MASK: next_rdata[2:0] = irq_mask;
		`SSPU_ADDR_AUX: next_rdata[3:0] = aux_serial_control;
		`SSPU_ADDR_FLAGS: next_rdata[4:0] = flags;
		`SSPU_ADDR_SMR4: next_rdata[3:0] = special_mode_control_4;
		default: next_rdata = 32'h0000_0000;
		endcase
	end

	// Control registers and interrupt bookkeeping
	always @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			channel_control_0 <= `SSPU_CTRL0_RST;
			channel_control_1 <= `SSPU_CTRL1_RST;
			aux_serial_control <= `SSPU_AUX_RST;
			special_mode_control_4 <= `SSPU_SMR4_RST;
			irq_mask <= 3'h0;
			irq_stat <= 3'h0;
			o_irq <= 1'b0;
			sim_done <= 1'b0;
		end else begin
			if (wr_cyc) begin
				case (ap_addr)
				`SSPU_ADDR_CTRL0: channel_control_0 <= i_hwdata[4:0];
				`SSPU_ADDR_CTRL1: channel_control_1 <= i_hwdata[4:0];
				`SSPU_ADDR_IRQ_MASK: irq_mask <= i_hwdata[2:0];
				`SSPU_ADDR_AUX: aux_serial_control <= i_hwdata[3:0];
				// Request bits are stored as written; software keeps to the setup sequence
				`SSPU_ADDR_SMR4: special_mode_control_4 <= i_hwdata[3:0];
				default: ;
				endcase
			end
			irq_stat <= next_irq_stat;
			o_irq <= |(next_irq_stat & irq_mask);
			// The reset quirk fires once; later toggles of the bits do not repeat it
			if (channel_control_1[`SSPU_C1_SIM] & channel_control_1[`SSPU_C1_IRS]
				& channel_control_1[`SSPU_C1_ERE]) begin
				sim_done <= 1'b1;
			end
		end
	end

	// Buffers and shift engine
	always @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			transmit_buffer <= 8'h00;
			transmit_buffer_empty <= 1'b1;
			receive_buffer <= 8'h00;
			receive_buffer_full <= 1'b0;
			overrun_flag <= 1'b0;
			state <= ST_IDLE;
			tx_sh <= 8'h00;
			rx_sh <= 8'h00;
			bit_cnt <= 4'h0;
			rx_active <= 1'b0;
			shift_seen <= 1'b0;
			int_clk <= 1'b1;
			div_cnt <= 8'h00;
			clk_prev <= 1'b1;
			o_serial_data_out_pin <= 1'b1;
		end else begin
			clk_prev <= clk_now;
			if (wr_cyc && ap_addr == `SSPU_ADDR_TXBUF) begin
				transmit_buffer <= i_hwdata[7:0];
				transmit_buffer_empty <= 1'b0;
			end else if (tx_start) begin
				transmit_buffer_empty <= 1'b1;
			end
			// Overrun set wins over the clear by reading the receive buffer
			if (set_ev[`SSPU_IRQ_OVR]) begin
				overrun_flag <= 1'b1;
			end else if (rd_rx) begin
				overrun_flag <= 1'b0;
			end
			if (set_ev[`SSPU_IRQ_RX]) begin
				receive_buffer <= rx_word;
				receive_buffer_full <= 1'b1;
			end else if (set_ev[`SSPU_IRQ_OVR]) begin
				// Content is undefined after an overrun; the late word is kept
				receive_buffer <= rx_word;
			end else if (rd_rx) begin
				receive_buffer_full <= 1'b0;
			end
			case (state)
			ST_IDLE: begin
				int_clk <= idle_lvl;
				div_cnt <= 8'h00;
				if (tx_start) begin
					// Transmitter runs for reception too; the buffer word is the dummy data
					tx_sh <= transmit_buffer;
					rx_active <= channel_control_1[`SSPU_C1_RE];
					shift_seen <= 1'b0;
					bit_cnt <= 4'h0;
					state <= ST_SHIFT;
				end
			end
			ST_SHIFT: begin
				// Internal clock free-runs only inside a word; external shifts wait on peer edges
				if (!ext_clk) begin
					if (div_cnt == `SSPU_INT_HALF - 8'h01) begin
						div_cnt <= 8'h00;
						int_clk <= ~int_clk;
					end else begin
						div_cnt <= div_cnt + 8'h01;
					end
				end
				if (lead_edge) begin
					o_serial_data_out_pin <= tx_sh[0];
					// First leading edge marks the start of reception for the send-request pin
					shift_seen <= 1'b1;
				end
				if (trail_edge) begin
					rx_sh <= {rxd_s, rx_sh[7:1]};
					tx_sh <= {1'b1, tx_sh[7:1]};
					if (bit_cnt == 4'h7) begin
						state <= ST_IDLE;
						int_clk <= idle_lvl;
					end else begin
						bit_cnt <= bit_cnt + 4'h1;
					end
				end
			end
			default: state <= ST_IDLE;
			endcase
		end
	end

	// Pin drivers
	always @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_transfer_clock_pin <= 1'b1;
			o_transfer_clock_pin_oe <= 1'b0;
			o_request_to_send_out_n <= 1'b1;
			o_request_to_send_out_oe <= 1'b0;
		end else begin
			o_transfer_clock_pin <= int_clk;
			o_transfer_clock_pin_oe <= ~ext_clk & ~cutoff;
			// Send-request only acts with an external clock; otherwise the pin stays released
			o_request_to_send_out_oe <= channel_control_0[`SSPU_C0_RTS_SEL] & ext_clk & ~cutoff;
			o_request_to_send_out_n <= ~rx_ready;
		end
	end
endmodule // sspu_top

//--- pkg/sspu_regs.vh
`ifndef SSPU_REGS_VH
`define SSPU_REGS_VH

`define SSPU_ADDR_CTRL0 8'h00
`define SSPU_ADDR_CTRL1 8'h04
`define SSPU_ADDR_TXBUF 8'h08
`define SSPU_ADDR_RXBUF 8'h0c
`define SSPU_ADDR_IRQ_STAT 8'h10
`define SSPU_ADDR_IRQ_MASK 8'h14
`define SSPU_ADDR_AUX 8'h18
`define SSPU_ADDR_FLAGS 8'h1c
`define SSPU_ADDR_SMR4 8'h20

// channel_control_0 fields
`define SSPU_C0_POL 0
`define SSPU_C0_EXTCLK 1
`define SSPU_C0_RTS_SEL 2
`define SSPU_C0_CTS_SEL 3
`define SSPU_C0_CUTOFF 4
// channel_control_1 fields
`define SSPU_C1_TE 0
`define SSPU_C1_RE 1
`define SSPU_C1_IRS 2
`define SSPU_C1_ERE 3
`define SSPU_C1_SIM 4
// Interrupt status and mask fields
`define SSPU_IRQ_RX 0
`define SSPU_IRQ_TX 1
`define SSPU_IRQ_OVR 2
// aux_serial_control fields
`define SSPU_AUX_IDLE 0
`define SSPU_AUX_FUNC 1
`define SSPU_AUX_FLOAT 2
`define SSPU_AUX_INTCLK 3
// special_mode_control_4 fields
`define SSPU_S4_START_CONDITION_REQUEST 0
`define SSPU_S4_REPEATED_START_REQUEST 1
`define SSPU_S4_STOP_CONDITION_REQUEST 2
`define SSPU_S4_CSEL 3

`define SSPU_CTRL0_RST 5'h00
`define SSPU_CTRL1_RST 5'h00
`define SSPU_AUX_RST 4'h0
`define SSPU_SMR4_RST 4'h0

`define SSPU_CLK_NS 4
`define SSPU_INT_HALF 8'h04
`define SSPU_AUX_GLITCH_NS 10
`define SSPU_AUX_GLITCH_CYC ((`SSPU_AUX_GLITCH_NS) / (`SSPU_CLK_NS))

`endif

//--- verilog/sspu_sync.v
`timescale 1ns/1ns
module sspu_sync #(
	parameter W = 1
) (
	input wire i_core_clk,
	input wire i_rst_n,
	input wire [W-1:0] i_async,
	output wire [W-1:0] o_sync
);
	reg [W-1:0] stage1;
	reg [W-1:0] stage2;
	genvar g;
	generate
		for (g = 0; g < W; g = g + 1) begin : g_bit
			always @(posedge i_core_clk) begin
				if (!i_rst_n) begin
					stage1[g] <= 1'b0;
					stage2[g] <= 1'b0;
				end else begin
					stage1[g] <= i_async[g];
					stage2[g] <= stage1[g];
				end
			end
		end
	endgenerate
	assign o_sync = stage2;
endmodule // sspu_sync

//--- verilog/sspu_aux.v
`timescale 1ns/1ns
`include "sspu_regs.vh"
module sspu_aux (
	input wire i_core_clk,
	input wire i_rst_n,
	input wire [3:0] i_ctrl,
	output reg o_sout,
	output reg o_sout_oe
);
	localparam [31:0] GLITCH_CYC = `SSPU_AUX_GLITCH_CYC;
	reg func_prev;
	reg [2:0] cnt;
	wire arm;
	// Only the port-to-serial switch with driven output and internal clock shows the level
	assign arm = i_ctrl[`SSPU_AUX_FUNC] & ~func_prev & ~i_ctrl[`SSPU_AUX_FLOAT] & i_ctrl[`SSPU_AUX_INTCLK];
	always @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			func_prev <= 1'b0;
			cnt <= 3'h0;
			o_sout <= 1'b0;
			o_sout_oe <= 1'b0;
		end else begin
			func_prev <= i_ctrl[`SSPU_AUX_FUNC];
			o_sout <= i_ctrl[`SSPU_AUX_IDLE];
			if (arm) begin
				cnt <= GLITCH_CYC[2:0];
				o_sout_oe <= 1'b1;
			end else if (cnt > 3'h1) begin
				cnt <= cnt - 3'h1;
			end else begin
				cnt <= 3'h0;
				o_sout_oe <= 1'b0;
			end
		end
	end
endmodule // sspu_aux

//--- tb/sspu_top_asserts.sv
`timescale 1ns/1ns
module sspu_top_asserts (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_hsel,
	input wire logic [1:0] i_htrans,
	input wire logic i_hready,
	input wire logic o_hreadyout,
	input wire logic [31:0] o_hrdata,
	input wire logic o_hresp,
	input wire logic o_transfer_clock_pin,
	input wire logic o_transfer_clock_pin_oe,
	input wire logic o_request_to_send_out_oe,
	input wire logic o_aux_serial_out_pin_oe
);
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rst_n);
	sequence addr_phase;
		i_hsel && i_htrans[1] && i_hready;
	endsequence
	sequence one_wait;
		!o_hreadyout ##1 o_hreadyout;
	endsequence
	chk_bus_wait: assert property (addr_phase |=> one_wait)
		else $error("wait state wrong");
	chk_ready_back: assert property (!o_hreadyout |=> o_hreadyout)
		else $error("ready low too long");
	chk_resp_okay: assert property (o_hresp == 1'b0)
		else $error("error response");
	chk_rdata_high: assert property (o_hrdata[31:9] == 23'h0)
		else $error("read data upper bits set");
	chk_reset_idle: assert property ($rose(i_rst_n) |-> o_hreadyout && !o_transfer_clock_pin_oe
		&& !o_request_to_send_out_oe && !o_aux_serial_out_pin_oe) else $error("outputs busy after reset");
	chk_rts_intclk: assert property (o_transfer_clock_pin_oe |-> !o_request_to_send_out_oe)
		else $error("send request driven with internal clock");
	chk_int_half: assert property (o_transfer_clock_pin_oe && $changed(o_transfer_clock_pin) |=>
		$stable(o_transfer_clock_pin)[*3]) else $error("internal half period short");
	chk_aux_glitch: assert property ($rose(o_aux_serial_out_pin_oe) |=>
		o_aux_serial_out_pin_oe ##1 !o_aux_serial_out_pin_oe) else $error("aux output not floated");
endmodule // sspu_top_asserts

//--- tb/sspu_peer.sv
`timescale 1ns/1ns
module sspu_peer (
	input wire logic i_pol,
	input wire logic i_sdo,
	output wire logic o_clk,
	output logic o_sdi,
	output logic [7:0] o_got
);
	logic run;
	logic lvl;
	// Clock stands at its idle level between frames
	assign o_clk = run ? lvl : !i_pol;
	initial begin
		run = 1'b0;
		lvl = 1'b0;
		o_sdi = 1'b1;
		o_got = 8'h00;
	end
	task automatic send(input logic [7:0] d);
		run = 1'b1;
		for (int i = 0; i < 8; i++) begin
			lvl = i_pol;
			o_sdi = d[i];
			#24;
			lvl = !i_pol;
			o_got[i] = i_sdo;
			#24;
		end
		run = 1'b0;
		// Released line must not keep showing the last bit
		o_sdi = !d[7];
	endtask
endmodule // sspu_peer

//--- tb/test_sspu_top.sv
`timescale 1ns/1ns
`include "sspu_regs.vh"
module test_sspu_top;
	logic clk, rst_n, hsel, hwrite, nmi_n, cts_n, pol, ext;
	logic [1:0] htrans;
	logic [7:0] haddr, b, p;
	logic [31:0] hwdata, q, lfsr;
	wire hrdy, irq, ckoe, sdo, rts_n, rts_oe, auxo, auxoe, pk_ck, pk_sd;
	wire [31:0] hrdata;
	wire [7:0] got;
	int num_errors, compares;
	logic [31:0] cnt;
	sspu_top dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
		.i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hrdy), .o_hreadyout(hrdy),
		.o_hrdata(hrdata), .o_hresp(), .o_irq(irq), .i_transfer_clock_pin(pk_ck), .o_transfer_clock_pin(),
		.o_transfer_clock_pin_oe(ckoe), .i_serial_data_in_pin(ext ? pk_sd : sdo), .o_serial_data_out_pin(sdo),
		.i_clear_to_send_in_n(cts_n), .o_request_to_send_out_n(rts_n), .o_request_to_send_out_oe(rts_oe),
		.i_nmi_n(nmi_n), .o_aux_serial_out_pin(auxo), .o_aux_serial_out_pin_oe(auxoe));
	sspu_peer peer (.i_pol(pol), .i_sdo(sdo), .o_clk(pk_ck), .o_sdi(pk_sd), .o_got(got));
	function automatic logic [31:0] next_rand(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic complete_run;
		if (num_errors == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch at %0t: %h expected %h", $time, g, e);
		end
	endtask
	task automatic fail_if(input logic c);
		if (c) begin
			num_errors++;
			complete_run;
		end
	endtask
	task automatic wait_ready(inout int n);
		do begin
			@(posedge clk);
			n++;
		end while (hrdy !== 1'b1 && n < 20);
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		wait_ready(n);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_ready(n);
		q = hrdata;
		fail_if(n >= 20);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd_cmp(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		cmp(q, e);
	endtask
	task automatic wait_irq;
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 2000) begin
			@(posedge clk);
			n++;
		end
		fail_if(n >= 2000);
	endtask
	initial begin
		clk = 1'b0;
		forever #2 clk = !clk;
	end
	initial begin
		{rst_n, hsel, hwrite, nmi_n, cts_n, pol, ext} = 7'h0c;
		htrans = 2'h0;
		haddr = 8'h0;
		hwdata = 32'h0;
		lfsr = 32'h2bfa65d2;
		num_errors = 0;
		compares = 0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd_cmp(`SSPU_ADDR_CTRL0, 32'h0);
		wr(`SSPU_ADDR_CTRL1, 32'h1c);
		rd_cmp(`SSPU_ADDR_IRQ_STAT, 32'h2);
		wr(`SSPU_ADDR_IRQ_STAT, 32'h2);
		wr(`SSPU_ADDR_IRQ_MASK, 32'h1);
		wr(`SSPU_ADDR_CTRL1, 32'h3);
		wr(`SSPU_ADDR_IRQ_STAT, 32'h7);
		// Internal clock, data out looped back to data in
		for (int k = 0; k < 4; k++) begin
			lfsr = next_rand(lfsr);
			b = lfsr[7:0];
			wr(`SSPU_ADDR_TXBUF, {24'h0, b});
			wait_irq;
			rd_cmp(`SSPU_ADDR_RXBUF, {24'h0, b});
			rd_cmp(`SSPU_ADDR_IRQ_STAT, 32'h3);
			wr(`SSPU_ADDR_IRQ_STAT, 32'h7);
		end
		wr(`SSPU_ADDR_TXBUF, 32'h5a);
		wait_irq;
		wr(`SSPU_ADDR_IRQ_STAT, 32'h7);
		wr(`SSPU_ADDR_IRQ_MASK, 32'h4);
		wr(`SSPU_ADDR_TXBUF, 32'ha5);
		wait_irq;
		rd_cmp(`SSPU_ADDR_IRQ_STAT, 32'h6);
		bus(1'b0, `SSPU_ADDR_RXBUF, 32'h0);
		cmp(q & 32'h100, 32'h100);
		wr(`SSPU_ADDR_IRQ_STAT, 32'h7);
		wr(`SSPU_ADDR_IRQ_MASK, 32'h1);
		ext <= 1'b1;
		for (int k = 0; k < 2; k++) begin
			wr(`SSPU_ADDR_CTRL0, {29'h0, 2'b11, k[0]});
			pol <= k[0];
			lfsr = next_rand(lfsr);
			{p, b} = lfsr[15:0];
			wr(`SSPU_ADDR_TXBUF, {24'h0, b});
			rd_cmp(`SSPU_ADDR_CTRL0, {29'h0, 2'b11, k[0]});
			cmp({30'h0, rts_oe, rts_n}, 32'h2);
			fork
				peer.send(p);
				#102 cmp({31'h0, rts_n}, 32'h1);
			join
			@(posedge clk);
			wait_irq;
			rd_cmp(`SSPU_ADDR_RXBUF, {24'h0, p});
			cmp({24'h0, got}, {24'h0, b});
			wr(`SSPU_ADDR_IRQ_STAT, 32'h7);
		end
		ext <= 1'b0;
		wr(`SSPU_ADDR_CTRL0, 32'h4);
		rd_cmp(`SSPU_ADDR_CTRL0, 32'h4);
		cmp({31'h0, rts_oe}, 32'h0);
		wr(`SSPU_ADDR_CTRL0, 32'h8);
		wr(`SSPU_ADDR_TXBUF, 32'h3c);
		repeat (6) rd_cmp(`SSPU_ADDR_FLAGS, 32'h0);
		cts_n <= 1'b0;
		wait_irq;
		rd_cmp(`SSPU_ADDR_RXBUF, 32'h3c);
		wr(`SSPU_ADDR_CTRL0, 32'h10);
		rd_cmp(`SSPU_ADDR_CTRL0, 32'h10);
		cmp({31'h0, ckoe}, 32'h1);
		nmi_n <= 1'b0;
		repeat (2) rd_cmp(`SSPU_ADDR_CTRL0, 32'h10);
		cmp({30'h0, ckoe, rts_oe}, 32'h0);
		nmi_n <= 1'b1;
		for (int k = 0; k < 3; k++) begin
			wr(`SSPU_ADDR_SMR4, 32'h0);
			repeat (5) @(posedge clk);
			wr(`SSPU_ADDR_SMR4, 32'h1 << k);
			rd_cmp(`SSPU_ADDR_SMR4, 32'h1 << k);
		end
		wr(`SSPU_ADDR_AUX, 32'h1);
		cnt = 0;
		fork
			wr(`SSPU_ADDR_AUX, 32'hb);
			repeat (12) begin
				@(posedge clk);
				cnt += auxoe & auxo;
			end
		join
		cmp(cnt, 2);
		wr(8'h24, 32'hffffffff);
		rd_cmp(8'h24, 32'h0);
		wr(`SSPU_ADDR_IRQ_STAT, 32'h7);
		rd_cmp(`SSPU_ADDR_IRQ_STAT, 32'h0);
		cmp({31'h0, irq}, 32'h0);
		complete_run;
	end
endmodule // test_sspu_top
bind sspu_top sspu_top_asserts chk (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_hsel(i_hsel),
	.i_htrans(i_htrans), .i_hready(i_hready), .o_hreadyout(o_hreadyout), .o_hrdata(o_hrdata),
	.o_hresp(o_hresp), .o_transfer_clock_pin(o_transfer_clock_pin),
	.o_transfer_clock_pin_oe(o_transfer_clock_pin_oe), .o_request_to_send_out_oe(o_request_to_send_out_oe),
	.o_aux_serial_out_pin_oe(o_aux_serial_out_pin_oe));
